/* File: shared/rpc_pkg.sv */
// Constants and types for the ROM-socket phantom calendar clock
package rpc_pkg;
  localparam int          ADDR_W          = 19;
  localparam logic [18:0] ZERO_BIT_OFFSET = 19'h0_0002;
  localparam logic [18:0] ONE_BIT_OFFSET  = 19'h0_0003;
  localparam logic [18:0] READ_BIT_OFFSET = 19'h0_0004;
  localparam logic [63:0] UNLOCK_KEY      = 64'h5CA3_3AC5_5CA3_3AC5;
  localparam int          KEY_BITS        = 64;
  localparam int          CLK_HZ          = 20000000;
  localparam int          TICK_MS         = 10;
  localparam int          TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int          HOUR_MODE_BIT   = 7;
  localparam int          HOUR_PM_BIT     = 5;
  localparam int          RESET_DIS_BIT   = 4;
  localparam logic [7:0]  DAY_RESET       = 8'h11;
  localparam logic [7:0]  DATE_RESET      = 8'h01;
  localparam logic [7:0]  MONTH_RESET     = 8'h01;

  typedef enum logic [1:0] {RPC_MATCH, RPC_WRITE, RPC_READ} rpc_state_t;

  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] minutes_count;
    logic [7:0] seconds_count;
    logic [7:0] hundredths_seconds;
  } rpc_time_t;
endpackage

/* File: hw/rpc_clock.sv */
// ROM-socket phantom calendar clock with read-cycle serial access
`timescale 1ns/1ns
module rpc_clock
  import rpc_pkg::*;
#(
  parameter int TICK_CYCLES_P = rpc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       reset_n_i,
  // ROM socket read strobe and address
  input  wire logic                       rom_read_i,
  input  wire logic [rpc_pkg::ADDR_W-1:0] rom_addr_i,
  // ROM socket data takeover
  output logic                            rom_override_o,
  output logic                            data_bit_o,
  // Current time for inspection
  output rpc_pkg::rpc_time_t              time_o
);
  import rpc_pkg::*;

  rpc_state_t  state_ff, nxt_state;
  logic [5:0]  bit_cnt_ff, nxt_bit_cnt;
  logic [63:0] shift_ff, nxt_shift;
  logic        dout_ff, nxt_dout;
  logic [31:0] tick_ff, nxt_tick;
  rpc_time_t   time_ff, nxt_time;

  // BCD helpers
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = ((y[7:4] * 4'd10 + y[3:0]) % 8'd4) == 8'd0;
    case (m)
      8'h02:   month_days = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
      default: month_days = 8'h31;
    endcase
  endfunction

  wire logic [18:0] off_w  = rom_addr_i;
  wire logic        is_wr  = (off_w == ZERO_BIT_OFFSET) || (off_w == ONE_BIT_OFFSET);
  wire logic        is_rd  = (off_w == READ_BIT_OFFSET);
  wire logic        in_bit = off_w[0];

  // Access sequencer
  always_comb begin
    nxt_state   = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift   = shift_ff;
    nxt_dout    = dout_ff;
    if (rom_read_i) begin
      case (state_ff)
        RPC_MATCH: begin
          if (is_wr && in_bit == UNLOCK_KEY[bit_cnt_ff]) begin
            nxt_bit_cnt = bit_cnt_ff + 6'd1;
            if (bit_cnt_ff == 6'(KEY_BITS - 1)) begin
              nxt_state = RPC_WRITE;
              nxt_shift = time_ff;
            end
          end else begin
            nxt_bit_cnt = 6'd0;
          end
        end
        RPC_WRITE: begin
          if (is_wr) begin
            nxt_shift   = {in_bit, shift_ff[63:1]};
            nxt_bit_cnt = bit_cnt_ff + 6'd1;
            if (bit_cnt_ff == 6'd63) begin
              nxt_state = RPC_MATCH;
            end
          end else if (is_rd && bit_cnt_ff == 6'd0) begin
            nxt_state   = RPC_READ;
            nxt_dout    = shift_ff[0];
            nxt_shift   = {1'b0, shift_ff[63:1]};
            nxt_bit_cnt = 6'd1;
          end else begin
            nxt_state   = RPC_MATCH;
            nxt_bit_cnt = 6'd0;
          end
        end
        RPC_READ: begin
          if (is_rd) begin
            nxt_dout    = shift_ff[0];
            nxt_shift   = {1'b0, shift_ff[63:1]};
            nxt_bit_cnt = bit_cnt_ff + 6'd1;
            if (bit_cnt_ff == 6'd63) begin
              nxt_state = RPC_MATCH;
            end
          end else begin
            nxt_state   = RPC_MATCH;
            nxt_bit_cnt = 6'd0;
          end
        end
        default: begin
          nxt_state   = RPC_MATCH;
          nxt_bit_cnt = 6'd0;
        end
      endcase
    end
  end

  wire logic load_w = rom_read_i && state_ff == RPC_WRITE && is_wr && bit_cnt_ff == 6'd63;

  // Timekeeping; a load takes priority over the tick
  always_comb begin
    nxt_tick = tick_ff;
    nxt_time = time_ff;
    if (load_w) begin
      nxt_time = {in_bit, shift_ff[63:1]};
      nxt_tick = 32'd0;
    end else if (tick_ff == 32'(TICK_CYCLES_P - 1)) begin
      nxt_tick = 32'd0;
      nxt_time.hundredths_seconds = bcd_inc(time_ff.hundredths_seconds);
      if (time_ff.hundredths_seconds == 8'h99) begin
        nxt_time.hundredths_seconds = 8'h00;
        nxt_time.seconds_count = bcd_inc(time_ff.seconds_count);
        if (time_ff.seconds_count == 8'h59) begin
          nxt_time.seconds_count = 8'h00;
          nxt_time.minutes_count = bcd_inc(time_ff.minutes_count);
          if (time_ff.minutes_count == 8'h59) begin
            nxt_time.minutes_count = 8'h00;
            if (time_ff.hour[HOUR_MODE_BIT]) begin
              nxt_time.hour[4:0] = 5'(bcd_inc({3'b000, time_ff.hour[4:0]}));
              if (time_ff.hour[4:0] == 5'h12) begin
                nxt_time.hour[4:0] = 5'h01;
              end
              if (time_ff.hour[4:0] == 5'h11) begin
                nxt_time.hour[HOUR_PM_BIT] = ~time_ff.hour[HOUR_PM_BIT];
              end
            end else begin
              nxt_time.hour = bcd_inc({2'b00, time_ff.hour[5:0]});
            end
            if ((!time_ff.hour[HOUR_MODE_BIT] && time_ff.hour[5:0] == 6'h23) ||
                (time_ff.hour[HOUR_MODE_BIT] && time_ff.hour[4:0] == 5'h11 && !time_ff.hour[HOUR_PM_BIT])) begin
              if (!time_ff.hour[HOUR_MODE_BIT]) begin
                nxt_time.hour = 8'h00;
              end
              nxt_time.day[2:0] = (time_ff.day[2:0] == 3'd7) ? 3'd1 : time_ff.day[2:0] + 3'd1;
              nxt_time.date = bcd_inc(time_ff.date);
              if (time_ff.date == month_days(time_ff.month, time_ff.year)) begin
                nxt_time.date  = 8'h01;
                nxt_time.month = bcd_inc(time_ff.month);
                if (time_ff.month == 8'h12) begin
                  nxt_time.month = 8'h01;
                  nxt_time.year  = (time_ff.year == 8'h99) ? 8'h00 : bcd_inc(time_ff.year);
                end
              end
            end
          end
        end
      end
    end else begin
      nxt_tick = tick_ff + 32'd1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff   <= RPC_MATCH;
      bit_cnt_ff <= 6'd0;
      shift_ff   <= 64'h0000_0000_0000_0000;
      dout_ff    <= 1'b0;
      tick_ff    <= 32'd0;
      time_ff    <= {8'h00, MONTH_RESET, DATE_RESET, DAY_RESET, 32'h0000_0000};
    end else begin
      state_ff   <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff   <= nxt_shift;
      dout_ff    <= nxt_dout;
      tick_ff    <= nxt_tick;
      time_ff    <= nxt_time;
    end
  end

  assign rom_override_o = (state_ff == RPC_READ);
  assign data_bit_o     = dout_ff;
  assign time_o         = time_ff;

  property p_unlock;
    @(posedge clk_i) disable iff (!reset_n_i)
      (state_ff == RPC_MATCH && nxt_state == RPC_WRITE) |-> bit_cnt_ff == 6'd63;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock without full key");

  property p_break;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rom_read_i && state_ff == RPC_MATCH && !is_wr) |=> bit_cnt_ff == 6'd0 && state_ff == RPC_MATCH;
  endproperty
  a_break: assert property (p_break) else $error("broken pattern not dropped");

  property p_load;
    @(posedge clk_i) disable iff (!reset_n_i)
      load_w |=> time_ff == {$past(in_bit), 63'($past(shift_ff) >> 1)};
  endproperty
  a_load: assert property (p_load) else $error("time load wrong");

  property p_readbit;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rom_read_i && state_ff == RPC_READ && is_rd) |=> data_bit_o == $past(shift_ff[0]);
  endproperty
  a_readbit: assert property (p_readbit) else $error("read bit wrong");

  property p_tick;
    @(posedge clk_i) disable iff (!reset_n_i)
      (tick_ff != 32'(TICK_CYCLES_P - 1) && !load_w) |=> $stable(time_ff.hundredths_seconds);
  endproperty
  a_tick: assert property (p_tick) else $error("time moved off tick");

  property p_override;
    @(posedge clk_i) disable iff (!reset_n_i)
      rom_override_o |-> state_ff == RPC_READ && bit_cnt_ff != 6'd0;
  endproperty
  a_override: assert property (p_override) else $error("override outside read");

  property p_leap;
    @(posedge clk_i) disable iff (!reset_n_i)
      (!load_w && time_ff.date == 8'h28 && time_ff.month == 8'h02 && time_ff.year == 8'h04 &&
       nxt_time.date != time_ff.date) |=> time_ff.date == 8'h29;
  endproperty
  a_leap: assert property (p_leap) else $error("leap day skipped");

  property p_hour12;
    @(posedge clk_i) disable iff (!reset_n_i)
      (!load_w && time_ff.hour[HOUR_MODE_BIT]) |=> time_ff.hour[HOUR_MODE_BIT];
  endproperty
  a_hour12: assert property (p_hour12) else $error("hour mode lost");

  // Roll points for the calendar checks
  wire logic hour_roll_w = !load_w && tick_ff == 32'(TICK_CYCLES_P - 1) && time_ff.hundredths_seconds == 8'h99 &&
                           time_ff.seconds_count == 8'h59 && time_ff.minutes_count == 8'h59;
  wire logic day_roll_w  = hour_roll_w &&
                           ((!time_ff.hour[HOUR_MODE_BIT] && time_ff.hour[5:0] == 6'h23) ||
                            (time_ff.hour[HOUR_MODE_BIT] && time_ff.hour[4:0] == 5'h11 && !time_ff.hour[HOUR_PM_BIT]));

  property p_sec_wrap;
    @(posedge clk_i) disable iff (!reset_n_i)
      (!load_w && tick_ff == 32'(TICK_CYCLES_P - 1) && time_ff.hundredths_seconds == 8'h99 &&
       time_ff.seconds_count == 8'h59) |=> time_ff.seconds_count == 8'h00 && time_ff.hundredths_seconds == 8'h00;
  endproperty
  a_sec_wrap: assert property (p_sec_wrap) else $error("seconds did not wrap");

  property p_hour24;
    @(posedge clk_i) disable iff (!reset_n_i)
      (hour_roll_w && !time_ff.hour[HOUR_MODE_BIT] && time_ff.hour[5:0] == 6'h23) |=> time_ff.hour == 8'h00;
  endproperty
  a_hour24: assert property (p_hour24) else $error("24-hour wrap wrong");

  property p_hour12_pm;
    @(posedge clk_i) disable iff (!reset_n_i)
      (hour_roll_w && time_ff.hour[HOUR_MODE_BIT] && time_ff.hour[4:0] == 5'h11) |=>
        time_ff.hour[4:0] == 5'h12 && $changed(time_ff.hour[HOUR_PM_BIT]);
  endproperty
  a_hour12_pm: assert property (p_hour12_pm) else $error("12-hour flag not toggled");

  property p_weekday;
    @(posedge clk_i) disable iff (!reset_n_i)
      (day_roll_w && time_ff.day[2:0] == 3'd7) |=> time_ff.day[2:0] == 3'd1;
  endproperty
  a_weekday: assert property (p_weekday) else $error("weekday wrap wrong");

  property p_year_wrap;
    @(posedge clk_i) disable iff (!reset_n_i)
      (day_roll_w && time_ff.date == 8'h31 && time_ff.month == 8'h12 && time_ff.year == 8'h99) |=>
        time_ff.year == 8'h00 && time_ff.month == 8'h01 && time_ff.date == 8'h01;
  endproperty
  a_year_wrap: assert property (p_year_wrap) else $error("year wrap wrong");

  // Data pin only moves on read-offset reads in read mode or on the first one after unlock
  property p_dout_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rom_read_i && state_ff == RPC_MATCH) |=> $stable(data_bit_o);
  endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("data bit moved while locked");

  property p_write_bit;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rom_read_i && state_ff == RPC_WRITE && is_wr) |=> shift_ff[63] == $past(in_bit);
  endproperty
  a_write_bit: assert property (p_write_bit) else $error("address bit not shifted in");
endmodule

/* File: test/rpc_host_model.sv */
// Host processor model issuing ROM read cycles to the clock window
`timescale 1ns/1ns
module rpc_host_model
  import rpc_pkg::*;
(
  // Clock
  input  wire logic                       clk_i,
  // ROM socket read strobe and address
  output logic                            rom_read_o,
  output logic [rpc_pkg::ADDR_W-1:0]      rom_addr_o,
  // Returned data and takeover flag
  input  wire logic                       data_bit_i,
  input  wire logic                       override_i
);
  int ovr_cnt = 0;

  initial begin
    rom_read_o = 1'b0;
    rom_addr_o = 19'h0_0000;
  end

  task automatic rd(input logic [18:0] off);
    @(negedge clk_i);
    rom_read_o = 1'b1;
    rom_addr_o = off;
    @(negedge clk_i);
    rom_read_o = 1'b0;
    // Released bus must not show a stale address
    rom_addr_o = ~off;
  endtask

  task automatic send_bit(input logic b);
    rd(b ? ONE_BIT_OFFSET : ZERO_BIT_OFFSET);
  endtask

  task automatic unlock(input int bad);
    rd(READ_BIT_OFFSET);
    for (int i = 0; i < KEY_BITS; i++) begin
      send_bit(UNLOCK_KEY[i] ^ (i == bad));
    end
  endtask

  task automatic write_time(input rpc_time_t t);
    t.day[RESET_DIS_BIT] = 1'b1;
    unlock(-1);
    for (int i = 0; i < 64; i++) begin
      send_bit(t[i]);
    end
  endtask

  task automatic read_time(output rpc_time_t t, input int bad);
    ovr_cnt = 0;
    unlock(bad);
    for (int i = 0; i < 64; i++) begin
      rd(READ_BIT_OFFSET);
      t[i] = data_bit_i;
      if (override_i !== 1'b0) begin
        ovr_cnt++;
      end
    end
  endtask
endmodule

/* File: test/rpc_clock_tb_top.sv */
// Self-checking bench for the ROM-socket phantom clock
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("CHECK FAILED %0t %s", $time, msg); end end
module rpc_clock_tb_top;
  import rpc_pkg::*;
  // Short tick keeps rollover checks quick
  localparam int TICK = 2000;
  logic              clk_i = 1'b0;
  logic              reset_n_i = 1'b0;
  logic              rom_read;
  logic              ovr;
  logic              dbit;
  logic [ADDR_W-1:0] rom_addr;
  rpc_time_t         time_o;
  rpc_time_t         rd_t;
  rpc_time_t         ld_t;
  int                err_total = 0;
  int                check_count = 0;

  always #25 clk_i = ~clk_i;

  rpc_clock #(.TICK_CYCLES_P(TICK)) dut_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .rom_read_i(rom_read), .rom_addr_i(rom_addr),
    .rom_override_o(ovr), .data_bit_o(dbit), .time_o(time_o));
  rpc_host_model host_u (
    .clk_i(clk_i), .rom_read_o(rom_read), .rom_addr_o(rom_addr), .data_bit_i(dbit), .override_i(ovr));

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Bounded wait for the next tick
  task automatic wait_change();
    rpc_time_t t0;
    int        n;
    t0 = time_o;
    n = 0;
    while (time_o === t0 && n < 3 * TICK) begin
      @(negedge clk_i);
      n++;
    end
  endtask

  task automatic t_reset();
    `CHK(time_o, 64'h0001_0111_0000_0000, "reset time")
    `CHK(ovr, 1'b0, "override at reset")
    `CHK(dbit, 1'b0, "data bit at reset")
  endtask

  // Load the last tick of 28 February in a leap year, watch it roll to the 29th
  task automatic t_leap();
    ld_t = {8'h04, 8'h02, 8'h28, 8'h17, 8'h23, 8'h59, 8'h59, 8'h99};
    host_u.write_time(ld_t);
    `CHK(time_o, ld_t, "loaded time")
    wait_change();
    `CHK(time_o, {8'h04, 8'h02, 8'h29, 8'h11, 8'h00, 8'h00, 8'h00, 8'h00}, "leap rollover")
  endtask

  // Twelve-hour 11 with PM bit clear at year end rolls to 12 with PM bit set
  task automatic t_hour12();
    ld_t = {8'h99, 8'h12, 8'h31, 8'h17, 8'h91, 8'h59, 8'h59, 8'h99};
    host_u.write_time(ld_t);
    `CHK(time_o, ld_t, "loaded 12h time")
    wait_change();
    `CHK(time_o, {8'h00, 8'h01, 8'h01, 8'h11, 8'hB2, 8'h00, 8'h00, 8'h00}, "12h and year rollover")
  endtask

  // Wrong key bit at first and last place
  task automatic t_broken();
    int pos [2] = '{0, 63};
    foreach (pos[k]) begin
      host_u.read_time(rd_t, pos[k]);
      `CHK(host_u.ovr_cnt, 0, "takeover after bad key")
    end
  endtask

  // Known time loaded well before the next tick, then read back
  task automatic t_read();
    ld_t = {8'h37, 8'h09, 8'h15, 8'h13, 8'h14, 8'h25, 8'h36, 8'h47};
    host_u.write_time(ld_t);
    host_u.read_time(rd_t, -1);
    `CHK(rd_t, ld_t, "serial read data")
    `CHK(host_u.ovr_cnt, 63, "takeover span")
    `CHK(ovr, 1'b0, "released after 64 reads")
  endtask

  // Reset in mid read drops takeover and time
  task automatic t_midreset();
    host_u.unlock(-1);
    host_u.rd(READ_BIT_OFFSET);
    `CHK(ovr, 1'b1, "takeover before reset")
    reset_n_i = 1'b0;
    #1;
    `CHK(ovr, 1'b0, "override in reset")
    `CHK(time_o, 64'h0001_0111_0000_0000, "time in reset")
    @(negedge clk_i);
    reset_n_i = 1'b1;
    host_u.rd(READ_BIT_OFFSET);
    `CHK(ovr, 1'b0, "no takeover after reset")
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    reset_n_i = 1'b1;
    t_reset();
    t_leap();
    t_hour12();
    t_broken();
    t_read();
    t_midreset();
    give_verdict();
  end

  // Hang guard well past the expected run
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    give_verdict();
  end
endmodule
